/* File: src/fsap_pkg.sv */
// Constants, field layout, command codes and timing of the status and
// array-protection block. Assumes an 8 MB array addressed by 24 bits.
// Behaviour
// - complement flag inverts the selected protected region
// - protect field picks upper, lower, top, bottom region
// - status one: lock lo, protect field, latch, busy
// - status two: paused, complement, locks, quad, lock hi
// - quad_on always reads one, never written
// - busy_flag high while program, erase, status write run
// - write_latch shows the internal write-enable latch
// - latch clear refuses status write, program, erase
// - protect field survives reset and power cycle
// - protect field changes only by status_write_cmd
// - program and erase refused inside protected region
// - full erase allowed when low field zero, complement zero
// - full erase allowed when low field ones, complement one
// - security lock bits settable once, never cleared
// - lock bits select software, power-cycle or permanent lock
package fsap_pkg;

  // ==========================================================
  // array geometry
  localparam int          ADDR_W      = 24;
  localparam logic [23:0] ARRAY_LAST  = 24'h7FFFFF;
  localparam logic [23:0] BIG_UNIT    = 24'h020000;
  localparam logic [23:0] SMALL_UNIT  = 24'h001000;
  localparam logic [2:0]  SMALL_CAP   = 3'h3;
  localparam logic [23:0] PAGE_MASK   = 24'h0000FF;
  localparam logic [23:0] SECTOR_MASK = 24'h000FFF;
  localparam logic [23:0] BLK32_MASK  = 24'h007FFF;
  localparam logic [23:0] BLK64_MASK  = 24'h00FFFF;

  // ==========================================================
  // status register one field positions
  localparam int LOCK_LO_BIT  = 7;
  localparam int PROT_LSB     = 2;
  localparam int LATCH_BIT    = 1;
  localparam int BUSY_BIT     = 0;
  // status register two field positions, within its own byte
  localparam int ERASE_PAUSED_BIT = 7;
  localparam int CMP_BIT          = 6;
  localparam int SECREG_LSB       = 3;
  localparam int PROG_PAUSED_BIT  = 2;
  localparam int QUAD_BIT         = 1;
  localparam int LOCK_HI_BIT      = 0;
  localparam logic QUAD_VALUE     = 1'b1;

  // ==========================================================
  // command codes
  localparam logic [7:0] CMD_WREN    = 8'h06;
  localparam logic [7:0] CMD_WRDI    = 8'h04;
  localparam logic [7:0] CMD_RD_LOW  = 8'h05;
  localparam logic [7:0] CMD_RD_HIGH = 8'h35;
  localparam logic [7:0] CMD_WRITE_STATUS = 8'h01;
  localparam logic [7:0] CMD_PAGE    = 8'h02;
  localparam logic [7:0] CMD_SECTOR  = 8'h20;
  localparam logic [7:0] CMD_BLK32   = 8'h52;
  localparam logic [7:0] CMD_BLK64   = 8'hD8;
  localparam logic [7:0] CMD_FULL_A  = 8'h60;
  localparam logic [7:0] CMD_FULL_B  = 8'hC7;
  localparam logic [7:0] CMD_PAUSE   = 8'h75;
  localparam logic [7:0] CMD_RESUME  = 8'h7A;

  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int OP_TIME_NS    = 6400;
  localparam int OP_CYCLES     = (OP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    OP_NONE,
    OP_STATUS,
    OP_PROGRAM,
    OP_ERASE
  } fsap_op_t;

endpackage : fsap_pkg

/* File: src/fsap_region.sv */
// Decodes the protect field and complement flag into one contiguous
// protected address range. Pure combinational logic.
`timescale 1ns/1ns
module fsap_region
(
  input  wire logic [4:0]  protect_sel,
  input  wire logic        complement_flag,
  output logic             region_none,
  output logic [23:0]      region_lo,
  output logic [23:0]      region_hi
);

  logic [2:0]  low_field;
  logic        base_none;
  logic        base_all;
  logic [2:0]  shift;
  logic [23:0] size;
  logic [23:0] base_lo;
  logic [23:0] base_hi;

  // ==========================================================
  // uncomplemented region
  always_comb
  begin
    low_field = protect_sel[2:0];
    base_none = (low_field == 3'h0);
    base_all  = (low_field == 3'h7);
    shift     = low_field - 3'h1;
    if (protect_sel[4])
    begin
      // fine portions stop growing at 32KB
      if (shift > fsap_pkg::SMALL_CAP)
        shift = fsap_pkg::SMALL_CAP;
      size = fsap_pkg::SMALL_UNIT << shift;
    end
    else
      size = fsap_pkg::BIG_UNIT << shift;
    if (base_all)
    begin
      base_lo = 24'h000000;
      base_hi = fsap_pkg::ARRAY_LAST;
    end
    else if (!protect_sel[3])
    begin
      base_lo = fsap_pkg::ARRAY_LAST - size + 24'h000001;
      base_hi = fsap_pkg::ARRAY_LAST;
    end
    else
    begin
      base_lo = 24'h000000;
      base_hi = size - 24'h000001;
    end
  end

  // ==========================================================
  // complement: the region is always anchored at one end, so its
  // complement is contiguous too
  always_comb
  begin
    region_none = base_none;
    region_lo   = base_lo;
    region_hi   = base_hi;
    if (complement_flag)
    begin
      region_none = base_all;
      if (base_none)
      begin
        region_lo = 24'h000000;
        region_hi = fsap_pkg::ARRAY_LAST;
      end
      else if (base_lo == 24'h000000)
      begin
        region_lo = base_hi + 24'h000001;
        region_hi = fsap_pkg::ARRAY_LAST;
      end
      else
      begin
        region_lo = 24'h000000;
        region_hi = base_lo - 24'h000001;
      end
    end
  end

endmodule : fsap_region

/* File: src/fsap_status.sv */
// Status registers, write latch, busy timing and array protection of a
// serial flash. The serial pins are sampled by ref_clk, which must run
// at least eight times faster than the serial clock.
`timescale 1ns/1ns
module fsap_status
#(
  parameter int OP_CYCLES = fsap_pkg::OP_CYCLES
)
(
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        sclk,
  input  wire logic        cs_n,
  input  wire logic        si,
  output logic             so_out,
  output logic             so_oe_n,
  input  wire logic [15:0] nv_image,
  output logic [7:0]       status_low,
  output logic [7:0]       status_high,
  output logic             busy_flag,
  output logic             write_latch
);

  // ==========================================================
  // pin synchronisers
  logic [1:0] sclk_sync;
  logic       sclk_prev;
  logic [1:0] cs_sync;
  logic       cs_prev;
  logic [1:0] si_sync;

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      sclk_sync <= 2'h0;
      sclk_prev <= 1'b0;
      cs_sync   <= 2'h3;
      cs_prev   <= 1'b1;
      si_sync   <= 2'h0;
    end
    else
    begin
      sclk_sync <= {sclk_sync[0], sclk};
      sclk_prev <= sclk_sync[1];
      cs_sync   <= {cs_sync[0], cs_n};
      cs_prev   <= cs_sync[1];
      si_sync   <= {si_sync[0], si};
    end
  end

  logic sclk_rise;
  logic sclk_fall;
  logic selected;
  logic cs_rise;
  assign sclk_rise = sclk_sync[1] & ~sclk_prev;
  assign sclk_fall = ~sclk_sync[1] & sclk_prev;
  assign selected  = ~cs_sync[1];
  assign cs_rise   = cs_sync[1] & ~cs_prev;

  // ==========================================================
  // serial framing: command byte, then address or data bytes
  logic [2:0]  bit_cnt;
  logic [3:0]  byte_cnt;
  logic [6:0]  rx;
  logic [7:0]  cmd;
  logic [23:0] addr;
  logic [7:0]  data_low;
  logic [7:0]  data_high;
  logic [7:0]  next_byte;
  assign next_byte = {rx, si_sync[1]};

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n || !selected)
    begin
      bit_cnt  <= 3'h0;
      byte_cnt <= 4'h0;
      rx       <= 7'h00;
    end
    else if (sclk_rise)
    begin
      rx      <= next_byte[6:0];
      bit_cnt <= bit_cnt + 3'h1;
      if (bit_cnt == 3'h7 && byte_cnt != 4'hF)
        byte_cnt <= byte_cnt + 4'h1;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      cmd       <= 8'h00;
      addr      <= 24'h000000;
      data_low  <= 8'h00;
      data_high <= 8'h00;
    end
    else if (selected && sclk_rise && bit_cnt == 3'h7)
    begin
      if (byte_cnt == 4'h0)
        cmd <= next_byte;
      if (byte_cnt >= 4'h1 && byte_cnt <= 4'h3)
        addr <= {addr[15:0], next_byte};
      if (byte_cnt == 4'h1)
        data_low <= next_byte;
      if (byte_cnt == 4'h2)
        data_high <= next_byte;
    end
  end

  // ==========================================================
  // stored bits and live status
  logic       lock_lo;
  logic       lock_hi;
  logic [4:0] protect_sel;
  logic       complement_flag;
  logic [2:0] secreg_lock;
  logic       erase_paused;
  logic       program_paused;
  logic       region_none;
  logic [23:0] region_lo;
  logic [23:0] region_hi;
  logic [23:0] span_lo;
  logic [23:0] span_hi;
  logic       hits_region;
  logic       full_ok;
  logic       status_ok;
  logic       frame_whole;
  logic       do_status;
  logic       do_program;
  logic       do_erase;
  logic [15:0] op_cnt;
  logic [7:0] so_shift;
  logic       reading;

  // suspend sequencing lives outside this block, so both stay clear
  assign erase_paused   = 1'b0;
  assign program_paused = 1'b0;

  assign status_low  = {lock_lo, protect_sel, write_latch, busy_flag};
  assign status_high = {erase_paused, complement_flag, secreg_lock, program_paused,
                        fsap_pkg::QUAD_VALUE, lock_hi};

  // ==========================================================
  // non-volatile bits: loaded from the image at power-up
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      lock_lo         <= nv_image[fsap_pkg::LOCK_LO_BIT];
      protect_sel     <= nv_image[fsap_pkg::PROT_LSB +: 5];
      complement_flag <= nv_image[8 + fsap_pkg::CMP_BIT];
      secreg_lock     <= nv_image[8 + fsap_pkg::SECREG_LSB +: 3];
      // a power cycle releases the supply lock-down, not the permanent one
      lock_hi         <= nv_image[8 + fsap_pkg::LOCK_HI_BIT]
                         & nv_image[fsap_pkg::LOCK_LO_BIT];
    end
    else if (do_status)
    begin
      // latch and busy bits of the data byte are ignored
      lock_lo     <= data_low[fsap_pkg::LOCK_LO_BIT];
      protect_sel <= data_low[fsap_pkg::PROT_LSB +: 5];
      if (byte_cnt == 4'h3)
      begin
        complement_flag <= data_high[fsap_pkg::CMP_BIT];
        secreg_lock     <= secreg_lock | data_high[fsap_pkg::SECREG_LSB +: 3];
        lock_hi         <= data_high[fsap_pkg::LOCK_HI_BIT];
      end
    end
  end

  // ==========================================================
  // protection decode
  fsap_region region
  (
    .protect_sel     (protect_sel),
    .complement_flag (complement_flag),
    .region_none     (region_none),
    .region_lo       (region_lo),
    .region_hi       (region_hi)
  );

  always_comb
  begin
    frame_whole = cs_rise && (bit_cnt == 3'h0);
    case (cmd)
      fsap_pkg::CMD_PAGE:
      begin
        span_lo = addr & ~fsap_pkg::PAGE_MASK;
        span_hi = addr | fsap_pkg::PAGE_MASK;
      end
      fsap_pkg::CMD_SECTOR:
      begin
        span_lo = addr & ~fsap_pkg::SECTOR_MASK;
        span_hi = addr | fsap_pkg::SECTOR_MASK;
      end
      fsap_pkg::CMD_BLK32:
      begin
        span_lo = addr & ~fsap_pkg::BLK32_MASK;
        span_hi = addr | fsap_pkg::BLK32_MASK;
      end
      fsap_pkg::CMD_BLK64:
      begin
        span_lo = addr & ~fsap_pkg::BLK64_MASK;
        span_hi = addr | fsap_pkg::BLK64_MASK;
      end
      default:
      begin
        span_lo = addr;
        span_hi = addr;
      end
    endcase
    // any overlap with the protected range refuses the whole operation
    hits_region = !region_none && (span_lo <= region_hi) && (span_hi >= region_lo);
    full_ok = ((protect_sel[2:0] == 3'h0) && !complement_flag)
              || ((protect_sel[2:0] == 3'h7) && complement_flag);
    status_ok = write_latch && !lock_hi && !busy_flag;
    do_status = frame_whole && (cmd == fsap_pkg::CMD_WRITE_STATUS)
                && ((byte_cnt == 4'h2) || (byte_cnt == 4'h3)) && status_ok;
    do_program = frame_whole && (cmd == fsap_pkg::CMD_PAGE) && (byte_cnt >= 4'h5)
                 && write_latch && !busy_flag && !hits_region;
    do_erase = frame_whole && write_latch && !busy_flag
               && ((((cmd == fsap_pkg::CMD_SECTOR) || (cmd == fsap_pkg::CMD_BLK32)
                     || (cmd == fsap_pkg::CMD_BLK64)) && (byte_cnt == 4'h4)
                    && !hits_region)
                   || (((cmd == fsap_pkg::CMD_FULL_A) || (cmd == fsap_pkg::CMD_FULL_B))
                       && (byte_cnt == 4'h1) && full_ok));
  end

  // ==========================================================
  // write-enable latch
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      write_latch <= 1'b0;
    else if (do_status || do_program || do_erase)
      write_latch <= 1'b0;
    else if (frame_whole && (byte_cnt == 4'h1) && (cmd == fsap_pkg::CMD_WREN))
      write_latch <= 1'b1;
    else if (frame_whole && (byte_cnt == 4'h1) && (cmd == fsap_pkg::CMD_WRDI))
      write_latch <= 1'b0;
  end

  // ==========================================================
  // operation timer
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      busy_flag <= 1'b0;
      op_cnt    <= 16'h0000;
    end
    else if (do_status || do_program || do_erase)
    begin
      busy_flag <= 1'b1;
      op_cnt    <= 16'(OP_CYCLES - 1);
    end
    else if (busy_flag)
    begin
      if (op_cnt == 16'h0000)
        busy_flag <= 1'b0;
      else
        op_cnt <= op_cnt - 16'h0001;
    end
  end

  // ==========================================================
  // status read-out: msb first, launched on the falling serial edge
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      so_out   <= 1'b0;
      so_shift <= 8'h00;
      reading  <= 1'b0;
    end
    else if (!selected)
      reading <= 1'b0;
    else if (sclk_fall)
    begin
      // reload at every byte boundary so the host may keep polling
      if ((byte_cnt != 4'h0) && (bit_cnt == 3'h0) && (cmd == fsap_pkg::CMD_RD_LOW))
      begin
        reading  <= 1'b1;
        so_out   <= status_low[7];
        so_shift <= {status_low[6:0], 1'b0};
      end
      else if ((byte_cnt != 4'h0) && (bit_cnt == 3'h0)
               && (cmd == fsap_pkg::CMD_RD_HIGH))
      begin
        reading  <= 1'b1;
        so_out   <= status_high[7];
        so_shift <= {status_high[6:0], 1'b0};
      end
      else
      begin
        so_out   <= so_shift[7];
        so_shift <= {so_shift[6:0], 1'b0};
      end
    end
  end

  assign so_oe_n = ~(reading & selected);

endmodule : fsap_status

/* File: testbench/flash_status_and_array_protection_bench.sv */
// Bench top: host model drives the serial pins, outputs are judged here.
// Assumes the non-volatile image is blank at power-up.
`timescale 1ns/1ns
module flash_status_and_array_protection_bench;
  // ==========================================================
  // harness
  logic        ref_clk = 1'h0;
  logic        rst_n = 1'h0;
  logic [15:0] nv_image = 16'h0000;
  logic        sclk, cs_n, si, so_out, so_oe_n, busy_flag, write_latch;
  logic [7:0]  status_low, status_high;
  int          error_cnt = 0;
  int          tests_run = 0;
  always #50 ref_clk = ~ref_clk;
  // short operation time keeps the run brief
  fsap_status #(.OP_CYCLES(20)) dut (.ref_clk(ref_clk), .rst_n(rst_n), .sclk(sclk),
    .cs_n(cs_n), .si(si), .so_out(so_out), .so_oe_n(so_oe_n), .nv_image(nv_image),
    .status_low(status_low), .status_high(status_high), .busy_flag(busy_flag),
    .write_latch(write_latch));
  fsap_host host (.ref_clk(ref_clk), .so_out(so_out), .so_oe_n(so_oe_n), .sclk(sclk),
    .cs_n(cs_n), .si(si));

  task conclude;
    if (error_cnt == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : conclude

  task check(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task op(input logic [7:0] c, input logic [31:0] rest, input int n);
    host.frame({c, rest}, n);
    @(negedge ref_clk);
  endtask : op

  task wait_idle;
    int i;
    for (i = 0; i < 100 && busy_flag !== 1'h0; i++) @(negedge ref_clk);
    check("busy idle", 8'h00, {7'h0, busy_flag});
    if (busy_flag !== 1'h0) conclude();
  endtask : wait_idle

  task status_write_cmd(input logic [7:0] lo, input logic [7:0] hi);
    op(fsap_pkg::CMD_WREN, 32'h0, 1);
    check("latch", 8'h01, {7'h0, write_latch});
    op(fsap_pkg::CMD_WRITE_STATUS, {lo, hi, 16'h0}, 3);
    check("status busy", 8'h01, {7'h0, busy_flag});
    wait_idle();
  endtask : status_write_cmd

  // target address goes with one data byte; erase frames drop it by count
  task probe(input logic [7:0] c, input logic [23:0] a, input int n, input logic exp);
    op(fsap_pkg::CMD_WREN, 32'h0, 1);
    op(c, {a, 8'h5A}, n);
    check("op busy", {7'h0, exp}, {7'h0, busy_flag});
    wait_idle();
  endtask : probe

  // ==========================================================
  // scenarios
  task t_reset;
    check("status_low", 8'h00, status_low);
    check("status_high", 8'h02, status_high);
    op(fsap_pkg::CMD_RD_HIGH, 32'h0, 2);
    check("read high", 8'h02, host.rx);
    op(fsap_pkg::CMD_WRITE_STATUS, 32'h0400_0000, 3);
    check("unlatched write", 8'h00, status_low);
  endtask : t_reset

  task t_upper;
    probe(fsap_pkg::CMD_FULL_A, 24'h0, 1, 1'h1);
    status_write_cmd(8'h07, 8'h00);
    check("field write", 8'h04, status_low);
    check("quad kept", 8'h02, status_high);
    probe(fsap_pkg::CMD_PAGE, 24'h7E0000, 5, 1'h0);
    probe(fsap_pkg::CMD_PAGE, 24'h7DFF00, 5, 1'h1);
    probe(fsap_pkg::CMD_SECTOR, 24'h7FF000, 4, 1'h0);
    probe(fsap_pkg::CMD_FULL_B, 24'h0, 1, 1'h0);
  endtask : t_upper

  task t_complement;
    status_write_cmd(8'h24, 8'h40);
    check("cmp write", 8'h42, status_high);
    probe(fsap_pkg::CMD_PAGE, 24'h01FF00, 5, 1'h1);
    probe(fsap_pkg::CMD_BLK64, 24'h020000, 4, 1'h0);
    probe(fsap_pkg::CMD_FULL_A, 24'h0, 1, 1'h0);
  endtask : t_complement

  initial
  begin
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'h1;
    @(negedge ref_clk);
    t_reset();
    t_upper();
    t_complement();
    conclude();
  end
endmodule : flash_status_and_array_protection_bench

bind fsap_status fsap_status_assertions chk (.ref_clk(ref_clk), .rst_n(rst_n),
  .status_low(status_low), .status_high(status_high), .busy_flag(busy_flag),
  .write_latch(write_latch));

/* File: testbench/fsap_host.sv */
// Host controller model: frames bytes on sclk, cs_n and si, reads so.
// Assumes mode 0 framing, sclk idle low, at one eighth of ref_clk.
`timescale 1ns/1ns
module fsap_host
(
  input  wire logic ref_clk,
  input  wire logic so_out,
  input  wire logic so_oe_n,
  output logic      sclk,
  output logic      cs_n,
  output logic      si
);
  // ==========================================================
  // line model and framing
  logic [7:0] rx = 8'h00;
  logic       last_so = 1'h0;
  logic       so_line;
  initial sclk = 1'h0;
  initial cs_n = 1'h1;
  initial si = 1'h0;
  // a released line shows the inverse of its last value, never a stale copy
  always @(posedge ref_clk) if (!so_oe_n) last_so <= so_out;
  assign so_line = so_oe_n ? ~last_so : so_out;

  // whole bytes only, msb first; sclk stands still outside the frame
  task frame(input logic [39:0] d, input int nbytes);
    int i;
    @(posedge ref_clk);
    cs_n <= 1'h0;
    for (i = 0; i < nbytes * 8; i++)
    begin
      si <= d[39 - i];
      repeat (4) @(posedge ref_clk);
      sclk <= 1'h1;
      rx <= {rx[6:0], so_line};
      repeat (4) @(posedge ref_clk);
      sclk <= 1'h0;
    end
    repeat (4) @(posedge ref_clk);
    cs_n <= 1'h1;
    si <= ~si;
    repeat (8) @(posedge ref_clk);
  endtask : frame
endmodule : fsap_host

/* File: testbench/fsap_status_assertions.sv */
// Checker for the status block: watches only the top-level ports.
// Assumes one clock domain, ref_clk, with synchronous active-low reset.
`timescale 1ns/1ns
module fsap_status_assertions
(
  input wire logic       ref_clk,
  input wire logic       rst_n,
  input wire logic [7:0] status_low,
  input wire logic [7:0] status_high,
  input wire logic       busy_flag,
  input wire logic       write_latch
);
  // ==========================================================
  // properties
  // long enough for any shortened operation time used in the bench
  localparam int MAX_BUSY = 300;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  a_quad_fixed:
    assert property (status_high[1] == 1'h1) else $error("quad bit not one");
  a_busy_shown:
    assert property (busy_flag == status_low[0]) else $error("busy bit mismatch");
  a_latch_shown:
    assert property (write_latch == status_low[1]) else $error("latch bit mismatch");
  a_busy_needs_latch:
    assert property ($rose(busy_flag) |-> $past(write_latch) || $past(write_latch, 2))
    else $error("operation started without latch");
  a_field_by_write:
    assert property (!$stable(status_low[6:2]) |-> busy_flag || $past(busy_flag))
    else $error("protect field moved outside a write");
  a_secreg_sticky:
    assert property ((~status_high[5:3] & $past(status_high[5:3])) == 3'h0)
    else $error("security lock cleared");
  a_busy_ends:
    assert property ($rose(busy_flag) |-> ##[1:MAX_BUSY] !busy_flag)
    else $error("busy never ended");
  a_lock_holds:
    assert property (status_high[0] && $past(status_high[0]) |-> $stable(status_low[7:2]))
    else $error("locked status changed");
endmodule : fsap_status_assertions
